/* adc_seq_cfg.svh */
// timing counts, field positions and codes for the conversion sequencer
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH

`define CLK_PERIOD_NS       20
`define CONVERSION_TICK_CLOCK_DIV_DEFAULT    4
`define STROBE_MIN_NS       40
`define CONV_TICKS          18
`define ACQ_TICKS           3
`define START_SPACING_TICKS 21
`define SLOW_PERIOD_TICKS   42
`define DOZE_WAKE_TICKS     3
`define SLOW_GAP_TICKS      (`SLOW_PERIOD_TICKS - `CONV_TICKS - `ACQ_TICKS)
`define SLOW_GAP_DOZE_TICKS (`SLOW_GAP_TICKS - `DOZE_WAKE_TICKS)
`define DEEP_ENTRY_NS       2000
`define DEEP_ENTRY_CYC      (`DEEP_ENTRY_NS / `CLK_PERIOD_NS)
`define DOZE_ENTRY_NS       200
`define DOZE_ENTRY_CYC      (`DOZE_ENTRY_NS / `CLK_PERIOD_NS)
`define DEEP_WAKE_NS        1000
`define DEEP_WAKE_CYC       ((`DEEP_WAKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CMD_MSB             15
`define CMD_LSB             12
`define CFG_MSB             11
`define CMD_WAKE            4'hB
`define CMD_DEFAULT         4'hF
`define STAT_EOC            2'h3
`define STAT_INT            2'h2
`define RESET_CHANNEL       3'h0

`endif

/* adc_seq_pkg.sv */
// types shared by the conversion sequencer
package adc_seq_pkg;
   typedef enum logic [2:0] {
      st_idle = 3'h0,
      st_acq  = 3'h1,
      st_conv = 3'h3,
      st_gap  = 3'h2,
      st_wake = 3'h6
   } seq_state_e;
   typedef logic [7:0] tmr_t;
endpackage

/* adc_conversion_sequencer.sv */
// conversion start, status pin and power-down control of a SAR converter
// Notes on behaviour
// - falling start strobe switches the input stage from sample to hold
// - every conversion lasts 18 conversion clock ticks
// - start strobe is accepted whatever the frame select level
// - auto trigger starts conversions with no strobe at all
// - auto trigger fast rate: 3 acquisition ticks after each end, 21 period
// - status function 11 shows conversion-done for the conversion time
// - manual trigger: done pin asserts right after strobe falls, drops at end
// - fast auto trigger: done pin idles 3 ticks before asserting again
// - status function 10: interrupt set at conversion end, cleared by read
// - status polarity bit picks the active level of the status pin
// - doze and deep power-down follow their enable bits
// - deep power-down settles within 2 us and needs 1 us to wake
// - wake, default command, soft reset or clearing bit ends power-down
// - doze wakes in 3 ticks and settles within 200 ns
// - auto doze puts the core to sleep after the next conversion end
// - auto doze wakes on start, channel, default, wake command, bit clear
// - slow auto rate spaces internal starts 42 ticks apart, fast 21
// - auto doze with auto trigger only works at the slow rate
// - command word: upper nibble command, lower 12 bits configuration
// - auto channel: start at last channel, step up, wrap to start channel
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"

module adc_conversion_sequencer
   import adc_seq_pkg::*;
#(
   parameter int CONVERSION_TICK_CLOCK_DIV     = `CONVERSION_TICK_CLOCK_DIV_DEFAULT,
   parameter int NUM_CHANNELS = 8
) (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        conversion_start_n,
   input  wire logic        frame_select_n,
   input  wire logic        trigger_mode_bit,
   input  wire logic        sample_rate_bit,
   input  wire logic [1:0]  status_pin_function,
   input  wire logic        status_polarity_bit,
   input  wire logic        auto_doze_enable_bit,
   input  wire logic        doze_enable_bit,
   input  wire logic        deep_powerdown_enable_bit,
   input  wire logic        software_reset_bit,
   input  wire logic        channel_select_mode_bit,
   input  wire logic [15:0] command_word,
   input  wire logic        command_valid,
   output logic             sample_hold,
   output logic             convert_start,
   output logic             convert_done,
   output logic             status_pin,
   output logic [2:0]       active_channel,
   output logic             analog_doze,
   output logic             analog_deep,
   output logic             powerdown_settled
);

   localparam int   DW_LO     = `DEEP_WAKE_CYC;
   localparam int   DZ_HI     = 4;
   localparam tmr_t DIV_LAST  = tmr_t'(CONVERSION_TICK_CLOCK_DIV - 1);
   localparam tmr_t CONV_LAST = tmr_t'(`CONV_TICKS - 1);
   localparam tmr_t ACQ_LAST  = tmr_t'(`ACQ_TICKS - 1);
   localparam tmr_t GAP_LAST  = tmr_t'(`SLOW_GAP_TICKS - 1);
   localparam tmr_t GAPD_LAST = tmr_t'(`SLOW_GAP_DOZE_TICKS - 1);
   localparam tmr_t DEEP_WAKE = tmr_t'(`DEEP_WAKE_CYC);
   localparam tmr_t DOZE_WAKE = tmr_t'(`DOZE_WAKE_TICKS * CONVERSION_TICK_CLOCK_DIV);
   localparam tmr_t DEEP_SET  = tmr_t'(`DEEP_ENTRY_CYC);
   localparam tmr_t DOZE_SET  = tmr_t'(`DOZE_ENTRY_CYC);
   localparam logic [2:0] LAST_CH = 3'(NUM_CHANNELS - 1);

   function automatic logic [3:0] cmd_nibble(input logic [15:0] word);
      cmd_nibble = word[`CMD_MSB:`CMD_LSB];
   endfunction
   function automatic logic drive_level(input logic active, input logic pol);
      drive_level = pol ? active : ~active;
   endfunction

   seq_state_e state;
   tmr_t       cnt, div_cnt, wake_timer, pd_timer;
   logic [1:0] start_sync, frame_sync;
   logic       start_q, frame_q, tick, deep_on, doze_on, auto_asleep;
   logic       deep_prev, doze_prev, mode_prev, irq_flag;
   logic [2:0] start_channel;
   logic [7:0] conv_ticks, acq_ticks;
   logic       start_fall, read_fall, auto_trig, ad_ok, cmd_chan_sel, wake_event;
   logic       core_ready, conv_end, conv_begin, manual_go, seq_wake_req;
   logic       leave_deep, leave_doze, auto_clear, next_converting, next_irq, any_down;
   default clocking chk_clk @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   // pins cross into clk through two flops; the second stage and a third flop holding its previous value are read
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         start_sync <= 2'h3;
         frame_sync <= 2'h3;
         start_q    <= 1'b1;
         frame_q    <= 1'b1;
      end else begin
         start_sync <= {start_sync[0], conversion_start_n};
         frame_sync <= {frame_sync[0], frame_select_n};
         start_q    <= start_sync[1];
         frame_q    <= frame_sync[1];
      end
   end

   // frame select plays no part in starting a conversion
   assign start_fall = start_q & ~start_sync[1];
   assign read_fall  = frame_q & ~frame_sync[1];

   // conversion clock derived from the system clock
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         div_cnt <= 8'h00;
         tick    <= 1'b0;
      end else begin
         tick    <= (div_cnt == DIV_LAST);
         div_cnt <= (div_cnt == DIV_LAST) ? 8'h00 : div_cnt + 8'h01;
      end
   end

   assign auto_trig    = ~trigger_mode_bit;
   assign ad_ok        = auto_doze_enable_bit & (trigger_mode_bit | sample_rate_bit);
   assign cmd_chan_sel = command_valid & ~command_word[`CMD_MSB];
   assign wake_event   = software_reset_bit | (command_valid &
                         ((cmd_nibble(command_word) == `CMD_WAKE) |
                          (cmd_nibble(command_word) == `CMD_DEFAULT)));
   assign core_ready   = ~deep_on & ~doze_on & (wake_timer == 8'h00);
   assign conv_end   = (state == st_conv) && tick && (cnt == CONV_LAST);
   assign manual_go  = (state == st_idle) && ~auto_trig && start_fall &&
                       core_ready && ~auto_asleep;
   assign conv_begin = manual_go || ((state == st_acq) && tick && (cnt == ACQ_LAST));
   assign seq_wake_req = ((state == st_idle) && core_ready && auto_asleep &&
                          (auto_trig || start_fall)) ||
                         ((state == st_gap) && tick && (cnt == GAPD_LAST) &&
                          auto_asleep && auto_trig);
   assign auto_clear = wake_event | cmd_chan_sel | ~ad_ok | seq_wake_req;
   assign leave_deep = deep_on & (wake_event | ~deep_powerdown_enable_bit);
   assign leave_doze = (doze_on & (wake_event | ~doze_enable_bit)) |
                       (auto_asleep & auto_clear & ~(conv_end & ad_ok));

   // power-down states: entered on an enable edge, left on any wake cause
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         deep_on   <= 1'b0;
         doze_on   <= 1'b0;
         deep_prev <= 1'b0;
         doze_prev <= 1'b0;
      end else begin
         deep_prev <= deep_powerdown_enable_bit;
         doze_prev <= doze_enable_bit;
         if (leave_deep)
            deep_on <= 1'b0;
         else if (deep_powerdown_enable_bit && !deep_prev)
            deep_on <= 1'b1;
         if (doze_on && (wake_event || !doze_enable_bit))
            doze_on <= 1'b0;
         else if (doze_enable_bit && !doze_prev)
            doze_on <= 1'b1;
      end
   end

   // the end of conversion wins over a wake cause in the same cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         auto_asleep <= 1'b0;
      else if (conv_end && ad_ok)
         auto_asleep <= 1'b1;
      else if (auto_clear)
         auto_asleep <= 1'b0;
   end

   // wake-up interval before the core may sample again
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         wake_timer <= 8'h00;
      else if (leave_deep)
         wake_timer <= DEEP_WAKE;
      else if (leave_doze)
         wake_timer <= DOZE_WAKE;
      else if (wake_timer != 8'h00)
         wake_timer <= wake_timer - 8'h01;
   end

   assign any_down = deep_on | doze_on | auto_asleep;
   // settling after entry, deep takes longer than doze
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pd_timer          <= 8'h00;
         powerdown_settled <= 1'b0;
         analog_doze       <= 1'b0;
         analog_deep       <= 1'b0;
      end else begin
         analog_deep <= deep_on;
         analog_doze <= (doze_on | auto_asleep) & ~deep_on;
         if (!any_down) begin
            pd_timer          <= 8'h00;
            powerdown_settled <= 1'b0;
         end else if (deep_on && !analog_deep) begin
            pd_timer          <= DEEP_SET;
            powerdown_settled <= 1'b0;
         end else if (!deep_on && !analog_doze) begin
            pd_timer          <= DOZE_SET;
            powerdown_settled <= 1'b0;
         end else if (pd_timer > 8'h01) begin
            pd_timer <= pd_timer - 8'h01;
         end else begin
            powerdown_settled <= 1'b1;
         end
      end
   end

   // sequencer; cnt counts conversion clock ticks within a state
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= st_idle;
         cnt   <= 8'h00;
      end else if (software_reset_bit) begin
         state <= st_idle;
         cnt   <= 8'h00;
      end else begin
         unique case (state)
            st_idle: begin
               cnt <= 8'h00;
               if (seq_wake_req)
                  state <= st_wake;
               else if (auto_trig && core_ready)
                  state <= st_acq;
               else if (manual_go)
                  state <= st_conv;
            end
            st_wake: begin
               cnt <= 8'h00;
               if (core_ready)
                  state <= st_acq;
            end
            st_acq: begin
               if (tick) begin
                  cnt <= (cnt == ACQ_LAST) ? 8'h00 : cnt + 8'h01;
                  if (cnt == ACQ_LAST)
                     state <= st_conv;
               end
            end
            st_conv: begin
               if (tick) begin
                  cnt <= (cnt == CONV_LAST) ? 8'h00 : cnt + 8'h01;
                  if (cnt == CONV_LAST) begin
                     if (!auto_trig)
                        state <= st_idle;
                     else if (sample_rate_bit)
                        state <= st_gap;
                     else
                        state <= st_acq;
                  end
               end
            end
            st_gap: begin
               // dozing core spends three of the gap ticks waking up
               if (!auto_trig) begin
                  state <= st_idle;
                  cnt   <= 8'h00;
               end else if (tick) begin
                  cnt <= cnt + 8'h01;
                  if (auto_asleep && cnt == GAPD_LAST) begin
                     state <= st_wake;
                     cnt   <= 8'h00;
                  end else if (!auto_asleep && cnt >= GAP_LAST) begin
                     state <= st_acq;
                     cnt   <= 8'h00;
                  end
               end
            end
         endcase
      end
   end

   assign next_converting = ~software_reset_bit & (conv_begin | (sample_hold & ~conv_end));
   // a read in the same cycle as a conversion end leaves the flag set
   assign next_irq = ~software_reset_bit & (conv_end | (irq_flag & ~read_fall));
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sample_hold   <= 1'b0;
         convert_start <= 1'b0;
         convert_done  <= 1'b0;
         irq_flag      <= 1'b0;
         status_pin    <= 1'b1;
      end else begin
         sample_hold   <= next_converting;
         convert_start <= conv_begin;
         convert_done  <= conv_end;
         irq_flag      <= next_irq;
         if (status_pin_function == `STAT_EOC)
            status_pin <= drive_level(next_converting, status_polarity_bit);
         else if (status_pin_function == `STAT_INT)
            status_pin <= drive_level(next_irq, status_polarity_bit);
         else
            status_pin <= drive_level(1'b0, status_polarity_bit);
      end
   end

   // channel sequencing; manual changes only while channel_select_mode_bit is clear
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         active_channel <= `RESET_CHANNEL;
         start_channel  <= `RESET_CHANNEL;
         mode_prev      <= 1'b0;
      end else begin
         mode_prev <= channel_select_mode_bit;
         if (channel_select_mode_bit && !mode_prev)
            start_channel <= active_channel;
         if (channel_select_mode_bit && conv_end)
            active_channel <= (active_channel >= LAST_CH) ? start_channel
                              : active_channel + 3'h1;
         else if (!channel_select_mode_bit && cmd_chan_sel &&
                  command_word[14:12] <= LAST_CH)
            active_channel <= command_word[14:12];
      end
   end

   // helper tick counts for the checks below
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         conv_ticks <= 8'h00;
         acq_ticks  <= 8'h00;
      end else begin
         if (conv_begin)
            conv_ticks <= 8'h00;
         else if (state == st_conv && tick)
            conv_ticks <= conv_ticks + 8'h01;
         if (state != st_acq)
            acq_ticks <= 8'h00;
         else if (tick)
            acq_ticks <= acq_ticks + 8'h01;
      end
   end

   chk_hold_on_fall: assert property (manual_go && !software_reset_bit |=>
      sample_hold && state == st_conv) else $error("strobe fall did not enter hold");
   chk_frame_ignored: assert property (manual_go && frame_q && !software_reset_bit |=>
      convert_start) else $error("start lost while frame select high");
   chk_conv_length: assert property ($fell(sample_hold) && !$past(software_reset_bit)
      |-> conv_ticks == 8'd18) else $error("conversion not 18 ticks");
   chk_auto_start: assert property (state == st_idle && auto_trig && core_ready &&
      !auto_asleep && !software_reset_bit |=> state == st_acq)
      else $error("auto trigger did not start");
   chk_acq_three: assert property ($rose(sample_hold) && $past(state) == st_acq |->
      $past(acq_ticks) == 8'd2) else $error("acquisition not 3 ticks");
   chk_eoc_level: assert property ($past(status_pin_function) == `STAT_EOC &&
      $stable(status_polarity_bit) |-> status_pin == (status_polarity_bit ? sample_hold
      : !sample_hold)) else $error("done pin does not follow conversion");
   chk_int_set: assert property (conv_end && status_pin_function == `STAT_INT &&
      !software_reset_bit |=> status_pin == status_polarity_bit)
      else $error("interrupt not set at end");
   chk_int_clear: assert property (read_fall && !conv_end &&
      status_pin_function == `STAT_INT |=> status_pin == !status_polarity_bit)
      else $error("interrupt not cleared by read");
   chk_deep_wake: assert property (leave_deep |-> ##[DW_LO:DW_LO] !core_ready)
      else $error("deep wake interval too short");
   chk_doze_entry: assert property ($rose(doze_on) && !deep_on ##1
      (doze_on && !deep_on)[*8] |-> ##[0:DZ_HI] powerdown_settled)
      else $error("doze entry not settled in time");
   chk_wake_ignore: assert property (wake_timer != 8'h00 |-> !conv_begin)
      else $error("conversion started during wake-up");

endmodule // adc_conversion_sequencer

/* host_model.sv */
// host side model: drives the shared conversion start strobe
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"

module host_model (
   input  wire logic clk,
   output logic      conversion_start_n
);
   int cyc;
   int last_fall;

   initial begin
      conversion_start_n = 1'b1;
      cyc                = 0;
      last_fall          = -1000;
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
   end

   // spacing is enforced here so the bench never issues an illegal strobe
   task automatic strobe();
      while (cyc - last_fall < `START_SPACING_TICKS * `CONVERSION_TICK_CLOCK_DIV_DEFAULT) @(negedge clk);
      @(negedge clk);
      conversion_start_n = 1'b0;
      last_fall          = cyc;
      repeat (3) @(negedge clk);
      conversion_start_n = 1'b1;
   endtask
endmodule // host_model

/* tb_top.sv */
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"

module tb_top;
   logic        clk = 1'b0;
   logic        arst_n, conversion_start_n, frame_select_n, trigger_mode_bit;
   logic        sample_rate_bit, status_polarity_bit, auto_doze_enable_bit;
   logic        doze_enable_bit, deep_powerdown_enable_bit, software_reset_bit;
   logic        channel_select_mode_bit, command_valid;
   logic [1:0]  status_pin_function;
   logic [15:0] command_word;
   logic        sample_hold, convert_start, convert_done, status_pin;
   logic [2:0]  active_channel;
   logic        analog_doze, analog_deep, powerdown_settled;
   int          err_total = 0;
   int          check_count = 0;
   int          n, len;
   logic        mid, fin;

   always #10 clk = ~clk;

   adc_conversion_sequencer #(.CONVERSION_TICK_CLOCK_DIV(`CONVERSION_TICK_CLOCK_DIV_DEFAULT), .NUM_CHANNELS(8))
   i_adc_conversion_sequencer (
      .clk(clk), .arst_n(arst_n), .conversion_start_n(conversion_start_n),
      .frame_select_n(frame_select_n), .trigger_mode_bit(trigger_mode_bit),
      .sample_rate_bit(sample_rate_bit), .status_pin_function(status_pin_function),
      .status_polarity_bit(status_polarity_bit),
      .auto_doze_enable_bit(auto_doze_enable_bit), .doze_enable_bit(doze_enable_bit),
      .deep_powerdown_enable_bit(deep_powerdown_enable_bit),
      .software_reset_bit(software_reset_bit),
      .channel_select_mode_bit(channel_select_mode_bit), .command_word(command_word),
      .command_valid(command_valid), .sample_hold(sample_hold),
      .convert_start(convert_start), .convert_done(convert_done),
      .status_pin(status_pin), .active_channel(active_channel),
      .analog_doze(analog_doze), .analog_deep(analog_deep),
      .powerdown_settled(powerdown_settled));

   host_model i_host_model (.clk(clk), .conversion_start_n(conversion_start_n));

   task automatic complete_run();
      if (err_total == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic pick(input int sel);
      case (sel)
         0: return convert_start;
         1: return convert_done;
         default: return powerdown_settled;
      endcase
   endfunction

   task automatic wait_sig(input int sel, input int lim, output int cnt);
      cnt = 0;
      do begin
         @(negedge clk);
         cnt++;
      end while (pick(sel) !== 1'b1 && cnt < lim);
   endtask

   task automatic send_cmd(input logic [3:0] nib);
      command_word  = {nib, 12'h000};
      command_valid = 1'b1;
      @(negedge clk);
      command_valid = 1'b0;
   endtask

   // one strobed conversion; len counts clocks from start pulse to done pulse
   task automatic conv(output int clen, output logic cmid, output logic cfin);
      int k;
      fork
         i_host_model.strobe();
         wait_sig(0, 150, k);
      join
      check("start_seen", 1'b1, k < 150);
      check("hold_on", 1'b1, sample_hold);
      clen = 0;
      cmid = 1'bx;
      while (convert_done !== 1'b1 && clen < 200) begin
         @(negedge clk);
         clen++;
         if (clen == 36) cmid = status_pin;
      end
      @(negedge clk);
      cfin = status_pin;
   endtask

   initial begin
      repeat (30000) @(posedge clk);
      err_total++;
      complete_run();
   end

   initial begin
      {arst_n, frame_select_n, trigger_mode_bit, sample_rate_bit} = 4'b0110;
      {status_pin_function, status_polarity_bit, auto_doze_enable_bit} = 4'b1100;
      {doze_enable_bit, deep_powerdown_enable_bit, software_reset_bit} = 3'b000;
      {channel_select_mode_bit, command_valid} = 2'b00;
      command_word = 16'h0000;
      repeat (10) @(negedge clk);
      check("reset_outs", 8'h40, {sample_hold, status_pin, active_channel,
                                  analog_doze, analog_deep, powerdown_settled});
      arst_n = 1'b1;
      repeat (3) @(negedge clk);
      for (int fs = 0; fs < 2; fs++) begin
         frame_select_n = fs[0];
         conv(len, mid, fin);
         check("conv_len", 1'b1, len >= 69 && len <= 75);
         check("done_mid", 1'b0, mid);
         check("done_end", 1'b1, fin);
      end
      status_pin_function = 2'h2;
      status_polarity_bit = 1'b1;
      frame_select_n      = 1'b0;
      conv(len, mid, fin);
      check("int_idle", 1'b0, mid);
      check("int_set", 1'b1, fin);
      frame_select_n = 1'b1;
      @(negedge clk);
      frame_select_n = 1'b0;
      repeat (6) @(negedge clk);
      check("int_clr", 1'b0, status_pin);
      frame_select_n = 1'b1;
      {status_pin_function, status_polarity_bit} = 3'b110;
      trigger_mode_bit     = 1'b0;
      auto_doze_enable_bit = 1'b1;
      wait_sig(0, 400, n);
      wait_sig(0, 400, n);
      check("fast_period", 16'd84, n[15:0]);
      check("fast_no_doze", 1'b0, analog_doze);
      while (status_pin !== 1'b1) @(negedge clk);
      n = 0;
      while (status_pin === 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      check("idle_gap", 16'd12, n[15:0]);
      auto_doze_enable_bit = 1'b0;
      sample_rate_bit      = 1'b1;
      wait_sig(0, 400, n);
      wait_sig(0, 400, n);
      check("slow_period", 16'd168, n[15:0]);
      trigger_mode_bit = 1'b1;
      sample_rate_bit  = 1'b0;
      wait_sig(1, 100, n);
      send_cmd(4'h6);
      @(negedge clk);
      check("chan_sel", 3'h6, active_channel);
      channel_select_mode_bit = 1'b1;
      conv(len, mid, fin);
      check("chan_step", 3'h7, active_channel);
      conv(len, mid, fin);
      check("chan_wrap", 3'h6, active_channel);
      channel_select_mode_bit = 1'b0;
      for (int k = 0; k < 4; k++) begin
         doze_enable_bit = 1'b1;
         wait_sig(2, 40, n);
         check("doze_settle", 1'b1, n <= `DOZE_ENTRY_CYC + 2);
         check("doze_on", 1'b1, analog_doze);
         if (k == 0) begin
            fork
               i_host_model.strobe();
               wait_sig(0, 100, n);
            join
            check("doze_refuse", 16'd100, n[15:0]);
         end
         case (k)
            0: send_cmd(`CMD_WAKE);
            1: send_cmd(`CMD_DEFAULT);
            2: begin
               software_reset_bit = 1'b1;
               @(negedge clk);
               software_reset_bit = 1'b0;
            end
            default: doze_enable_bit = 1'b0;
         endcase
         repeat (2) @(negedge clk);
         check("doze_wake", 1'b0, analog_doze);
         doze_enable_bit = 1'b0;
         repeat (20) @(negedge clk);
      end
      deep_powerdown_enable_bit = 1'b1;
      wait_sig(2, 200, n);
      check("deep_settle", 1'b1, n <= `DEEP_ENTRY_CYC + 2);
      check("deep_on", 1'b1, analog_deep);
      deep_powerdown_enable_bit = 1'b0;
      repeat (2) @(negedge clk);
      check("deep_off", 1'b0, analog_deep);
      fork
         i_host_model.strobe();
         wait_sig(0, 40, n);
      join
      check("deep_refuse", 16'd40, n[15:0]);
      fork
         i_host_model.strobe();
         wait_sig(0, 150, n);
      join
      check("deep_wake", 1'b1, n < 150);
      wait_sig(1, 100, n);
      auto_doze_enable_bit = 1'b1;
      conv(len, mid, fin);
      repeat (3) @(negedge clk);
      check("auto_doze", 1'b1, analog_doze);
      conv(len, mid, fin);
      check("auto_wake_len", 1'b1, len >= 69 && len <= 75);
      complete_run();
   end
endmodule // tb_top
